/* rtl/interrupt_enable_priority_regs.sv */
// interrupt enable and low priority registers with arbitration and event status
//
// Implementation choice: strobed register access.
`default_nettype none
`include "irq_regs_map.svh"
module interrupt_enable_priority_regs
    import irq_regs_pkg::*;
#(
    parameter int NUM_SRC = `IRQ_NUM_SRC
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // register port
    input wire irq_regs_pkg::sfr_addr_t i_addr,
    input wire irq_regs_pkg::sfr_byte_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output irq_regs_pkg::sfr_byte_t o_rdata,
    // single-bit write at i_addr
    input wire logic i_bit_wr,
    input wire irq_regs_pkg::bit_idx_t i_bit_idx,
    input wire logic i_bit_val,
    // interrupt sources and companion high priority bits
    input wire logic [NUM_SRC-1:0] i_src_req,
    input wire logic [NUM_SRC-1:0] i_prio_high,
    // selected request to the core
    output logic o_irq_valid,
    output irq_regs_pkg::src_idx_t o_irq_id,
    output irq_regs_pkg::prio_lvl_t o_irq_level,
    // summary interrupt
    output logic o_irq
);
    import irq_regs_pkg::*;

    sfr_byte_t ie_reg;
    sfr_byte_t ie_next;
    sfr_byte_t ip_reg;
    sfr_byte_t ip_next;
    sfr_byte_t rdata_reg;
    sfr_byte_t rdata_next;
    logic irq_valid_reg;
    src_idx_t irq_id_reg;
    prio_lvl_t irq_level_reg;
    logic irq_reg;
    logic [NUM_SRC-1:0] gated_req;
    logic hit_ie;
    logic hit_ip;
    logic hit_stat;
    logic hit_mask;

    irq_core_if #(.NUM_SRC(NUM_SRC)) core_bus ();

    // address decode
    assign hit_ie = (i_addr == `IRQ_IE_ADDR);
    assign hit_ip = (i_addr == `IRQ_IP_ADDR);
    assign hit_stat = (i_addr == `IRQ_STAT_ADDR);
    assign hit_mask = (i_addr == `IRQ_MASK_ADDR);

    // byte or single-bit write; reserved bits are never stored
    always_comb begin
        ie_next = ie_reg;
        if (hit_ie && i_wr) begin
            ie_next = i_wdata;
        end else if (hit_ie && i_bit_wr) begin
            ie_next[i_bit_idx] = i_bit_val;
        end
        ie_next = ie_next & `IRQ_IE_WMASK;
    end

    // same for the priority register
    always_comb begin
        ip_next = ip_reg;
        if (hit_ip && i_wr) begin
            ip_next = i_wdata;
        end else if (hit_ip && i_bit_wr) begin
            ip_next[i_bit_idx] = i_bit_val;
        end
        ip_next = ip_next & `IRQ_IP_WMASK;
    end

    // enable register, cleared at reset
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ie_reg <= `IRQ_IE_RST;
        end else begin
            ie_reg <= ie_next;
        end
    end

    // priority register; its reset value is not given, zero is safe
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ip_reg <= `IRQ_IP_RST;
        end else begin
            ip_reg <= ip_next;
        end
    end

    // global enable gates all sources, then each own enable
    // a blocked source is dropped here, before the arbiter and the status logic see it
    assign gated_req = i_src_req & ie_reg[NUM_SRC-1:0] & {NUM_SRC{ie_reg[`IRQ_EA_BIT]}};

    // feed arbiter and status logic
    assign core_bus.req = gated_req;
    assign core_bus.prio_low = ip_reg[NUM_SRC-1:0];
    assign core_bus.prio_high = i_prio_high;
    assign core_bus.clr_wr = hit_stat && i_wr;
    assign core_bus.clr_data = i_wdata[NUM_SRC-1:0];
    assign core_bus.mask_wr = hit_mask && i_wr;
    assign core_bus.mask_data = i_wdata[NUM_SRC-1:0];

    irq_arbiter #(.NUM_SRC(NUM_SRC)) u_arbiter (
        .bus(core_bus.arb)
    );

    irq_event_status #(.NUM_SRC(NUM_SRC)) u_status (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .bus(core_bus.stat)
    );

    // read mux; reserved bits and unmapped addresses read as zero
    always_comb begin
        rdata_next = `IRQ_RDATA_IDLE;
        if (i_rd) begin
            case (1'b1)
                hit_ie: rdata_next = ie_reg;
                hit_ip: rdata_next = ip_reg;
                hit_stat: rdata_next = sfr_byte_t'(core_bus.status);
                hit_mask: rdata_next = sfr_byte_t'(core_bus.mask);
                default: rdata_next = `IRQ_RDATA_IDLE;
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rdata_reg <= `IRQ_RDATA_IDLE;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // registered winner costs one cycle of latency but keeps outputs glitch free
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            irq_valid_reg <= 1'b0;
            irq_id_reg <= '0;
            irq_level_reg <= '0;
        end else begin
            irq_valid_reg <= core_bus.win_valid;
            irq_id_reg <= core_bus.win_id;
            irq_level_reg <= core_bus.win_lvl;
        end
    end

    // summary interrupt from unmasked sticky status
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= core_bus.pending;
        end
    end

    // outputs come straight from their flip-flops
    assign o_rdata = rdata_reg;
    assign o_irq_valid = irq_valid_reg;
    assign o_irq_id = irq_id_reg;
    assign o_irq_level = irq_level_reg;
    assign o_irq = irq_reg;

    // checking helpers: inputs of the previous cycle
    logic [NUM_SRC-1:0] gated_q;
    logic [NUM_SRC-1:0] ip_q;
    logic [NUM_SRC-1:0] hi_q;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            gated_q <= '0;
            ip_q <= '0;
            hi_q <= '0;
        end else begin
            gated_q <= gated_req;
            ip_q <= ip_reg[NUM_SRC-1:0];
            hi_q <= i_prio_high;
        end
    end

    // all checks below run on the core clock and stay quiet during reset, except chk_ie_reset, which watches reset itself
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    chk_global_block: assert property (
        !ie_reg[`IRQ_EA_BIT] |=> !o_irq_valid)
        else $error("interrupt passed with global enable clear");

    chk_enable_pass: assert property (
        ie_reg[`IRQ_EA_BIT] && (i_src_req & ie_reg[NUM_SRC-1:0]) != '0 |=> o_irq_valid)
        else $error("enabled request not presented");

    chk_enable_map: assert property (
        hit_ie && i_wr ##1 i_rd && hit_ie |=>
        o_rdata == ($past(i_wdata, 2) & `IRQ_IE_WMASK))
        else $error("enable register does not hold written bits");

    chk_source_gate: assert property (
        o_irq_valid |-> gated_q[o_irq_id])
        else $error("serviced source was not enabled");

    chk_reserved_read: assert property (
        i_rd && (hit_ie || hit_ip) |=> o_rdata[6] == 1'b0)
        else $error("reserved bit read back nonzero");

    chk_ie_reset: assert property (disable iff (1'b0)
        !i_rst_n |=> ie_reg == `IRQ_IE_RST && !o_irq_valid && !o_irq)
        else $error("enable register not cleared by reset");

    chk_bit_write: assert property (
        hit_ie && i_bit_wr && !i_wr && i_bit_idx != 3'h6 |=>
        ie_reg[$past(i_bit_idx)] == $past(i_bit_val))
        else $error("single-bit write to enable register lost");

    chk_prio_map: assert property (
        hit_ip && i_wr ##1 i_rd && hit_ip |=>
        o_rdata == ($past(i_wdata, 2) & `IRQ_IP_WMASK))
        else $error("priority register does not hold written bits");

    chk_level_form: assert property (
        o_irq_valid |-> o_irq_level == {hi_q[o_irq_id], ip_q[o_irq_id]})
        else $error("level is not the high and low bit pair");

    // no other pending source may outrank the winner
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_chk
        chk_poll_order: assert property (
            o_irq_valid && gated_q[i] |->
            ({hi_q[i], ip_q[i]} < o_irq_level) ||
            ({hi_q[i], ip_q[i]} == o_irq_level && src_idx_t'(i) >= o_irq_id))
            else $error("winner outranked by another request");
    end

    chk_irq_summary: assert property (
        o_irq |-> $past(core_bus.pending))
        else $error("summary interrupt without pending status");

    // a lone enabled request must come out as its own source, which checks the bit map
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_chk_map
        chk_source_map: assert property (
            ie_reg[`IRQ_EA_BIT] && ie_reg[i] && i_src_req == NUM_SRC'(1 << i) |=>
            o_irq_valid && o_irq_id == src_idx_t'(i))
            else $error("lone enabled request not presented as its source");
    end

    // a status bit may only rise after a request that passed both enables
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_chk_stat
        chk_status_source: assert property (
            $rose(core_bus.status[i]) |->
            $past(i_src_req[i]) && $past(ie_reg[i]) && $past(ie_reg[`IRQ_EA_BIT]))
            else $error("status set by a blocked source");
    end

    // reserved priority bits are never stored, so they cannot leak into a read
    chk_ip_reserved: assert property (
        i_rd && hit_ip |=> o_rdata[7:6] == 2'h0)
        else $error("reserved priority bits read back nonzero");

    // bit writes to priority bits 0 to 5 behave like those to the enable register; bit 7 of the priority register is not stored
    chk_ip_bit_write: assert property (
        hit_ip && i_bit_wr && !i_wr && i_bit_idx < 3'h6 |=>
        ip_reg[$past(i_bit_idx)] == $past(i_bit_val))
        else $error("single-bit write to priority register lost");

    // a byte left on the bus would be taken again by the next access
    chk_rdata_idle: assert property (
        !i_rd |=> o_rdata == `IRQ_RDATA_IDLE)
        else $error("read data stood longer than one cycle");

    // clearing the last unmasked bit drops the line two edges later, unless a new event came
    chk_irq_clear: assert property (
        core_bus.clr_wr && (core_bus.status & core_bus.mask & ~core_bus.clr_data) == '0 &&
        (gated_req & ~gated_q) == '0 |=> ##1 !o_irq)
        else $error("summary interrupt stayed up after its clear");

    cov_top_level: cover property (o_irq_valid && o_irq_level == 2'h3);
    cov_tie: cover property (o_irq_valid && $countones(gated_q) > 1);
    cov_blocked: cover property (!ie_reg[`IRQ_EA_BIT] && i_src_req != '0);
    cov_irq: cover property ($rose(o_irq));
    cov_bit_write: cover property (i_bit_wr && (hit_ie || hit_ip));
endmodule
`default_nettype wire

/* rtl/irq_regs_map.svh */
// register offsets, field positions and reset values of the interrupt enable/priority block
`ifndef IRQ_REGS_MAP_SVH
`define IRQ_REGS_MAP_SVH

// register offsets on the special function register bus
`define IRQ_IE_ADDR 8'ha8
`define IRQ_IP_ADDR 8'hb8
`define IRQ_STAT_ADDR 8'hf1
`define IRQ_MASK_ADDR 8'hf2

// field positions; the source bits are shared by enable, priority, status and mask registers, EA is in the enable register only
`define IRQ_EA_BIT 7
`define IRQ_EXT0_BIT 0
`define IRQ_TIMER0_BIT 1
`define IRQ_EXT1_BIT 2
`define IRQ_TIMER1_BIT 3
`define IRQ_SERIAL_BIT 4
`define IRQ_TIMER2_BIT 5
`define IRQ_NUM_SRC 6

// reset values and writable bits
`define IRQ_IE_RST 8'h00
`define IRQ_IP_RST 8'h00
`define IRQ_STAT_RST 8'h00
`define IRQ_MASK_RST 8'h00
`define IRQ_IE_WMASK 8'hbf
`define IRQ_IP_WMASK 8'h3f
`define IRQ_RDATA_IDLE 8'h00

`endif

/* rtl/irq_regs_pkg.sv */
// shared types of the interrupt enable/priority block
`default_nettype none
package irq_regs_pkg;
    typedef logic [7:0] sfr_addr_t;
    typedef logic [7:0] sfr_byte_t;
    typedef logic [2:0] src_idx_t;
    typedef logic [1:0] prio_lvl_t;
    typedef logic [2:0] bit_idx_t;
endpackage
`default_nettype wire

/* rtl/irq_core_if.sv */
// interface between the register block, the arbiter and the event status logic
`default_nettype none
interface irq_core_if #(parameter int NUM_SRC = 6);
    import irq_regs_pkg::*;
    // gated requests and their priority bits
    logic [NUM_SRC-1:0] req;
    logic [NUM_SRC-1:0] prio_low;
    logic [NUM_SRC-1:0] prio_high;
    // arbitration result
    logic win_valid;
    src_idx_t win_id;
    prio_lvl_t win_lvl;
    // status and mask access
    logic clr_wr;
    logic [NUM_SRC-1:0] clr_data;
    logic mask_wr;
    logic [NUM_SRC-1:0] mask_data;
    logic [NUM_SRC-1:0] status;
    logic [NUM_SRC-1:0] mask;
    logic pending;

    modport ctl (
        output req, prio_low, prio_high, clr_wr, clr_data, mask_wr, mask_data,
        input win_valid, win_id, win_lvl, status, mask, pending
    );
    modport arb (
        input req, prio_low, prio_high,
        output win_valid, win_id, win_lvl
    );
    modport stat (
        input req, clr_wr, clr_data, mask_wr, mask_data,
        output status, mask, pending
    );
endinterface
`default_nettype wire

/* rtl/irq_arbiter.sv */
// picks the winning request by four-level priority, then by fixed polling order
`default_nettype none
module irq_arbiter #(
    parameter int NUM_SRC = 6
) (
    irq_core_if.arb bus
);
    import irq_regs_pkg::*;

    prio_lvl_t lvl [NUM_SRC];

    // per-source level, high bit on top of the low bit
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_lvl
        assign lvl[i] = {bus.prio_high[i], bus.prio_low[i]};
    end

    // strict compare keeps the earliest index on a tie: that is the polling order
    always_comb begin
        bus.win_valid = 1'b0;
        bus.win_id = '0;
        bus.win_lvl = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (bus.req[i] && (!bus.win_valid || lvl[i] > bus.win_lvl)) begin
                bus.win_valid = 1'b1;
                bus.win_id = src_idx_t'(i);
                bus.win_lvl = lvl[i];
            end
        end
    end
endmodule
`default_nettype wire

/* rtl/irq_event_status.sv */
// sticky event status, write-one-to-clear, with mask and pending level
`default_nettype none
`include "irq_regs_map.svh"
module irq_event_status #(
    parameter int NUM_SRC = 6
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // link to the register block
    irq_core_if.stat bus
);
    import irq_regs_pkg::*;

    logic [NUM_SRC-1:0] req_prev_reg;
    logic [NUM_SRC-1:0] status_reg;
    logic [NUM_SRC-1:0] mask_reg;

    // previous gated request, so only a new request counts as an event
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            req_prev_reg <= '0;
        end else begin
            req_prev_reg <= bus.req;
        end
    end

    // per bit: a new event wins over a clear in the same cycle
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_stat
        always_ff @(posedge i_core_clk) begin
            if (!i_rst_n) begin
                status_reg[i] <= 1'(`IRQ_STAT_RST >> i);
            end else if (bus.req[i] && !req_prev_reg[i]) begin
                status_reg[i] <= 1'b1;
            end else if (bus.clr_wr && bus.clr_data[i]) begin
                status_reg[i] <= 1'b0;
            end
        end
    end

    // mask register, plain read/write
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            mask_reg <= NUM_SRC'(`IRQ_MASK_RST);
        end else if (bus.mask_wr) begin
            mask_reg <= bus.mask_data;
        end
    end

    assign bus.status = status_reg;
    assign bus.mask = mask_reg;
    assign bus.pending = |(status_reg & mask_reg);

    chk_set_wins: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        bus.req[0] && !req_prev_reg[0] && bus.clr_wr |=> status_reg[0])
        else $error("status event lost against a clear");
endmodule
`default_nettype wire

/* bench/irq_source_model.sv */
// far-side model: peripheral request lines and companion high priority bits
`default_nettype none
module irq_source_model (
    // clock
    input wire logic i_core_clk,
    // levels wanted by the test sequence
    input wire logic [5:0] i_want_req,
    input wire logic [5:0] i_want_high,
    // lines toward the block
    output logic [5:0] o_req,
    output logic [5:0] o_prio_high
);
    timeunit 1ns;
    timeprecision 1ps;
    // on-chip sources change just after an edge, never mid-cycle
    always_ff @(posedge i_core_clk) begin
        o_req <= i_want_req;
        o_prio_high <= i_want_high;
    end
endmodule
`default_nettype wire

/* bench/tb_interrupt_enable_priority_regs.sv */
// self-checking bench of the interrupt enable and priority registers
`default_nettype none
`include "irq_regs_map.svh"
module tb_interrupt_enable_priority_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_regs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    sfr_addr_t addr = 8'h00;
    sfr_byte_t wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic bit_wr = 1'b0;
    bit_idx_t bit_idx = 3'h0;
    logic bit_val = 1'b0;
    logic [5:0] want_req = 6'h00;
    logic [5:0] want_high = 6'h00;
    logic [5:0] src_req;
    logic [5:0] prio_high;
    sfr_byte_t rdata;
    logic irq_valid;
    src_idx_t irq_id;
    prio_lvl_t irq_level;
    logic irq;
    int fail_count = 0;
    int checks_done = 0;

    // clock generation
    initial begin
        forever #2.5 clk = ~clk;
    end

    irq_source_model src (
        .i_core_clk(clk),
        .i_want_req(want_req),
        .i_want_high(want_high),
        .o_req(src_req),
        .o_prio_high(prio_high)
    );

    interrupt_enable_priority_regs DUT (
        .i_core_clk(clk),
        .i_rst_n(rst_n),
        .i_addr(addr),
        .i_wdata(wdata),
        .i_wr(wr),
        .i_rd(rd),
        .o_rdata(rdata),
        .i_bit_wr(bit_wr),
        .i_bit_idx(bit_idx),
        .i_bit_val(bit_val),
        .i_src_req(src_req),
        .i_prio_high(prio_high),
        .o_irq_valid(irq_valid),
        .o_irq_id(irq_id),
        .o_irq_level(irq_level),
        .o_irq(irq)
    );

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input sfr_addr_t a, input sfr_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic wr_bit(input sfr_addr_t a, input bit_idx_t b, input logic v);
        @(posedge clk);
        addr <= a;
        bit_idx <= b;
        bit_val <= v;
        bit_wr <= 1'b1;
        @(posedge clk);
        bit_wr <= 1'b0;
    endtask

    // write then read back with no gap, as the bus allows
    task automatic wr_rd_chk(input sfr_addr_t a, input sfr_byte_t d, input sfr_byte_t exp);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check("read back", exp, rdata);
    endtask

    // a request rises in the very cycle that software clears its status bit
    task automatic clr_race(input logic [5:0] req, input sfr_byte_t clr);
        @(posedge clk);
        want_req <= req;
        @(posedge clk);
        addr <= `IRQ_STAT_ADDR;
        wdata <= clr;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so look right there
    task automatic rd_chk(input sfr_addr_t a, input sfr_byte_t exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check("read data", exp, rdata);
    endtask

    // one edge for the source model, one for the arbiter, one spare for o_irq
    task automatic arb_chk(input logic [5:0] req, input logic [5:0] high, input logic v,
                           input src_idx_t id, input prio_lvl_t lvl);
        @(posedge clk);
        want_req <= req;
        want_high <= high;
        repeat (3) @(posedge clk);
        #1;
        check("request valid", {7'h00, v}, {7'h00, irq_valid});
        if (v) begin
            check("winner id", {5'h00, id}, {5'h00, irq_id});
            check("winner level", {6'h00, lvl}, {6'h00, irq_level});
        end
    endtask

    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        #50000;
        fail_count++;
        stop_test();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(`IRQ_IE_ADDR, `IRQ_IE_RST);
        rd_chk(`IRQ_IP_ADDR, `IRQ_IP_RST);
        rd_chk(`IRQ_STAT_ADDR, 8'h00);
        wr_rd_chk(`IRQ_IE_ADDR, 8'hbf, 8'hbf);
        wr_rd_chk(`IRQ_IP_ADDR, 8'h3f, 8'h3f);
        wr_bit(`IRQ_IE_ADDR, 3'h7, 1'b0);
        rd_chk(`IRQ_IE_ADDR, 8'h3f);
        wr_bit(`IRQ_IP_ADDR, 3'h5, 1'b0);
        rd_chk(`IRQ_IP_ADDR, 8'h1f);
        wr_reg(8'h10, 8'h5a);
        rd_chk(8'h10, 8'h00);
        arb_chk(6'h3f, 6'h00, 1'b0, 3'h0, 2'h0);
        wr_reg(`IRQ_IP_ADDR, 8'h00);
        // each source alone, then all but that one
        for (int i = 0; i < 6; i++) begin
            wr_reg(`IRQ_IE_ADDR, 8'h80 | (8'h01 << i));
            arb_chk(6'h3f, 6'h00, 1'b1, i[2:0], 2'h0);
            arb_chk(6'h3f & ~(6'h01 << i), 6'h00, 1'b0, 3'h0, 2'h0);
        end
        wr_reg(`IRQ_IE_ADDR, 8'hbf);
        arb_chk(6'h3f, 6'h00, 1'b1, 3'h0, 2'h0);
        arb_chk(6'h3f, 6'h20, 1'b1, 3'h5, 2'h2);
        wr_reg(`IRQ_IP_ADDR, 8'h01);
        arb_chk(6'h3f, 6'h20, 1'b1, 3'h5, 2'h2);
        wr_reg(`IRQ_IP_ADDR, 8'h21);
        arb_chk(6'h3f, 6'h20, 1'b1, 3'h5, 2'h3);
        wr_reg(`IRQ_IP_ADDR, 8'h18);
        arb_chk(6'h3f, 6'h00, 1'b1, 3'h3, 2'h1);
        // sticky status, mask and summary interrupt
        arb_chk(6'h00, 6'h00, 1'b0, 3'h0, 2'h0);
        wr_reg(`IRQ_STAT_ADDR, 8'h3f);
        wr_reg(`IRQ_MASK_ADDR, 8'h01);
        wr_reg(`IRQ_IE_ADDR, 8'h83);
        arb_chk(6'h02, 6'h00, 1'b1, 3'h1, 2'h0);
        check("summary irq", 8'h00, {7'h00, irq});
        rd_chk(`IRQ_STAT_ADDR, 8'h02);
        arb_chk(6'h03, 6'h00, 1'b1, 3'h0, 2'h0);
        check("summary irq", 8'h01, {7'h00, irq});
        wr_reg(`IRQ_STAT_ADDR, 8'h01);
        rd_chk(`IRQ_STAT_ADDR, 8'h02);
        check("summary irq", 8'h00, {7'h00, irq});
        wr_reg(`IRQ_STAT_ADDR, 8'h02);
        rd_chk(`IRQ_STAT_ADDR, 8'h00);
        // event and clear in one cycle: the event must win
        arb_chk(6'h00, 6'h00, 1'b0, 3'h0, 2'h0);
        clr_race(6'h01, 8'h01);
        rd_chk(`IRQ_STAT_ADDR, 8'h01);
        check("summary irq", 8'h01, {7'h00, irq});
        // reset again in mid-run: enable, mask and status must be back at their reset values
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(`IRQ_IE_ADDR, `IRQ_IE_RST);
        rd_chk(`IRQ_MASK_ADDR, `IRQ_MASK_RST);
        rd_chk(`IRQ_STAT_ADDR, `IRQ_STAT_RST);
        check("summary irq", 8'h00, {7'h00, irq});
        check("request valid", 8'h00, {7'h00, irq_valid});
        stop_test();
    end
endmodule
`default_nettype wire
